// file: logic/level_event_detect.sv
`include "irq_cfg.svh"
// ***************************************************
// Timer wrap, supply and comparator event detector
// ***************************************************
module level_event_detect (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [7:0] timer0_count_i,
   input wire logic [9:0] timer1_count_i,
   input wire logic [9:0] timer2_count_i,
   input wire logic [9:0] timer3_count_i,
   input wire logic low_supply_ok_i,
   input wire logic comparator_out_i,
   input wire logic osc_ctrl_read_i,
   output logic [3:0] timer_event_o,
   output logic low_supply_event_o,
   output logic comparator_event_o
);
   typedef struct packed {
      logic [7:0] t0;
      logic [9:0] t1;
      logic [9:0] t2;
      logic [9:0] t3;
      logic [1:0] lvd_meta;
      logic lvd_prev;
      logic [1:0] cmp_meta;
      logic cmp_ref;
      logic cmp_armed;
   } led_s;
   led_s st_r;
   led_s st_nxt;
   function automatic logic under10(input logic [9:0] old_v, input logic [9:0] new_v);
      under10 = (old_v == `T13_MIN) && (new_v == `T13_MAX);
   endfunction
   always_comb begin
      st_nxt = st_r;
      st_nxt.t0 = timer0_count_i;
      st_nxt.t1 = timer1_count_i;
      st_nxt.t2 = timer2_count_i;
      st_nxt.t3 = timer3_count_i;
      st_nxt.lvd_meta = {st_r.lvd_meta[0], low_supply_ok_i};
      st_nxt.lvd_prev = st_r.lvd_meta[1];
      st_nxt.cmp_meta = {st_r.cmp_meta[0], comparator_out_i};
      // Reading the oscillator control register rebases the comparator reference
      if (osc_ctrl_read_i) begin
         st_nxt.cmp_ref = st_r.cmp_meta[1];
         st_nxt.cmp_armed = 1'b1;
      end else if (comparator_event_o) begin
         st_nxt.cmp_ref = st_r.cmp_meta[1];
      end
   end
   // Timer0 counts up and wraps, the others count down
   assign timer_event_o[0] = (st_r.t0 == `T0_MAX) && (timer0_count_i == `T0_MIN);
   assign timer_event_o[1] = under10(timer1_count_i, st_r.t1) ? 1'b0
      : under10(st_r.t1, timer1_count_i);
   assign timer_event_o[2] = under10(st_r.t2, timer2_count_i);
   assign timer_event_o[3] = under10(st_r.t3, timer3_count_i);
   assign low_supply_event_o = st_r.lvd_prev & ~st_r.lvd_meta[1];
   assign comparator_event_o = st_r.cmp_armed && (st_r.cmp_meta[1] != st_r.cmp_ref);
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
         st_r.lvd_prev <= 1'b1;
         st_r.lvd_meta <= 2'b11;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // level_event_detect

// file: logic/mcu_interrupt_unit.sv
`include "irq_cfg.svh"
// Overview of operation
// - Eleven hardware sources plus one software trap
// - Global enable gates hardware; set/clear instructions
// - Trap vectors to 0x001, clears global enable
// - Return sets global enable, resumes saved address
// - Event flags sticky until firmware writes zero
// - Flag readable only while its enable set
// - Enabled pending flag vectors to 0x008
// - Timer0 wrap sets timer0 flag
// - Timer1-3 underflow set their own flags
// - Watchdog flag set only in interrupt mode
// - Enabled input pin change sets pin flag
// - External select disables level change on pin
// - Selected edge sets external input flags
// - Supply falling below threshold sets flag
// - Comparator change raises request after rebase read
// - ADC end of conversion raises request
// - Watchdog flag and enable at bit six
module mcu_interrupt_unit (
   input wire logic clock_i,
   input wire logic rst_i,
   // Instruction sequencer
   input wire logic instr_done_i,
   input wire logic [11:0] next_pc_i,
   input wire logic soft_trap_instruction_i,
   input wire logic enable_irq_instruction_i,
   input wire logic disable_irq_instruction_i,
   input wire logic return_from_isr_instruction_i,
   // Event sources
   input wire logic [7:0] timer0_count_i,
   input wire logic [9:0] timer1_count_i,
   input wire logic [9:0] timer2_count_i,
   input wire logic [9:0] timer3_count_i,
   input wire logic watchdog_timeout_i,
   input wire logic watchdog_irq_mode_i,
   input wire logic [7:0] porta_i,
   input wire logic [5:0] portb_i,
   input wire logic [7:0] porta_input_mode_i,
   input wire logic [5:0] portb_input_mode_i,
   input wire logic [7:0] porta_change_wake_enable_i,
   input wire logic [5:0] portb_change_wake_enable_i,
   input wire logic ext0_pin_select_i,
   input wire logic ext1_pin_select_i,
   input wire logic ext_edge_polarity_i,
   input wire logic low_supply_ok_i,
   input wire logic comparator_out_i,
   input wire logic osc_ctrl_read_i,
   input wire logic adc_done_i,
   // Firmware access to flags and enables
   input wire logic [10:0] irq_enable_register_i,
   input wire logic flag_write_i,
   input wire logic [10:0] flag_write_data_i,
   output logic [10:0] irq_flag_register_o,
   output logic global_irq_enable_o,
   output logic redirect_o,
   output logic [11:0] redirect_pc_o,
   output logic [11:0] return_pc_o
);
   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      logic [10:0] flags;
      logic global_irq_enable;
      logic redirect;
      logic [11:0] vec;
      logic [11:0] ret;
      logic [10:0] flag_view;
      irq_pkg::vec_state_e fsm;
   } iu_s;
   iu_s st_r;
   iu_s st_nxt;
   logic [1:0] wdt_sync_r;
   logic [1:0] adc_sync_r;
   logic wdt_prev_r;
   logic adc_prev_r;
   logic pin_change;
   logic ext0_edge;
   logic ext1_edge;
   logic [3:0] timer_event;
   logic low_supply_event;
   logic comparator_event;
   logic [10:0] events;
   logic [10:0] flags_after;
   logic hard_pending;
   // ***************************************************
   // Event detectors
   // ***************************************************
   pin_change_detect u_pins (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .porta_i(porta_i),
      .portb_i(portb_i),
      .porta_input_mode_i(porta_input_mode_i),
      .portb_input_mode_i(portb_input_mode_i),
      .porta_change_wake_enable_i(porta_change_wake_enable_i),
      .portb_change_wake_enable_i(portb_change_wake_enable_i),
      .ext0_pin_select_i(ext0_pin_select_i),
      .ext1_pin_select_i(ext1_pin_select_i),
      .ext_edge_polarity_i(ext_edge_polarity_i),
      .pin_change_o(pin_change),
      .ext0_edge_o(ext0_edge),
      .ext1_edge_o(ext1_edge)
   );
   level_event_detect u_levels (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .timer0_count_i(timer0_count_i),
      .timer1_count_i(timer1_count_i),
      .timer2_count_i(timer2_count_i),
      .timer3_count_i(timer3_count_i),
      .low_supply_ok_i(low_supply_ok_i),
      .comparator_out_i(comparator_out_i),
      .osc_ctrl_read_i(osc_ctrl_read_i),
      .timer_event_o(timer_event),
      .low_supply_event_o(low_supply_event),
      .comparator_event_o(comparator_event)
   );
   // Watchdog and ADC strobes may come from slower domains
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wdt_sync_r <= 2'b00;
         adc_sync_r <= 2'b00;
         wdt_prev_r <= 1'b0;
         adc_prev_r <= 1'b0;
      end else begin
         wdt_sync_r <= {wdt_sync_r[0], watchdog_timeout_i};
         adc_sync_r <= {adc_sync_r[0], adc_done_i};
         wdt_prev_r <= wdt_sync_r[1];
         adc_prev_r <= adc_sync_r[1];
      end
   end
   // ***************************************************
   // Flag collection
   // ***************************************************
   always_comb begin
      events = '0;
      events[`SRC_T0] = timer_event[0];
      events[`SRC_T1] = timer_event[1];
      events[`SRC_T2] = timer_event[2];
      events[`SRC_T3] = timer_event[3];
      events[`SRC_PIN] = pin_change;
      events[`SRC_EXT0] = ext0_edge;
      events[`SRC_WDT] = wdt_sync_r[1] & ~wdt_prev_r & watchdog_irq_mode_i;
      events[`SRC_EXT1] = ext1_edge;
      events[`SRC_LVD] = low_supply_event;
      events[`SRC_CMP] = comparator_event;
      events[`SRC_ADC] = adc_sync_r[1] & ~adc_prev_r;
   end
   always_comb begin
      flags_after = st_r.flags;
      if (flag_write_i) begin
         flags_after = st_r.flags & flag_write_data_i;
      end
      // A new event beats a simultaneous firmware clear
      flags_after = flags_after | events;
   end
   // ***************************************************
   // Vectoring
   // ***************************************************
   assign hard_pending = |(st_r.flags & irq_enable_register_i);
   always_comb begin
      st_nxt = st_r;
      st_nxt.flags = flags_after;
      st_nxt.flag_view = flags_after & irq_enable_register_i;
      st_nxt.redirect = 1'b0;
      if (enable_irq_instruction_i) begin
         st_nxt.global_irq_enable = 1'b1;
      end else if (disable_irq_instruction_i) begin
         st_nxt.global_irq_enable = 1'b0;
      end else if (return_from_isr_instruction_i) begin
         st_nxt.global_irq_enable = 1'b1;
      end
      case (st_r.fsm)
         irq_pkg::ST_RUN: begin
            // Redirect only at an instruction boundary
            if (instr_done_i && soft_trap_instruction_i) begin
               st_nxt.fsm = irq_pkg::ST_SOFT;
               st_nxt.ret = next_pc_i;
            end else if (instr_done_i && st_r.global_irq_enable && hard_pending
                         && !disable_irq_instruction_i) begin
               st_nxt.fsm = irq_pkg::ST_HARD;
               st_nxt.ret = next_pc_i;
            end
         end
         irq_pkg::ST_SOFT: begin
            st_nxt.global_irq_enable = 1'b0;
            st_nxt.redirect = 1'b1;
            st_nxt.vec = `VEC_SOFT;
            st_nxt.fsm = irq_pkg::ST_RUN;
         end
         irq_pkg::ST_HARD: begin
            st_nxt.global_irq_enable = 1'b0;
            st_nxt.redirect = 1'b1;
            st_nxt.vec = `VEC_HARD;
            st_nxt.fsm = irq_pkg::ST_RUN;
         end
         default: begin
            st_nxt.fsm = irq_pkg::ST_RUN;
         end
      endcase
      if (return_from_isr_instruction_i && instr_done_i) begin
         st_nxt.redirect = 1'b1;
         st_nxt.vec = st_r.ret;
      end
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
         st_r.fsm <= irq_pkg::ST_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign irq_flag_register_o = st_r.flag_view;
   assign global_irq_enable_o = st_r.global_irq_enable;
   assign redirect_o = st_r.redirect;
   assign redirect_pc_o = st_r.vec;
   assign return_pc_o = st_r.ret;
   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   soft_vector_a: assert property ((instr_done_i && soft_trap_instruction_i
      && st_r.fsm == irq_pkg::ST_RUN) |-> ##2 (redirect_o && redirect_pc_o == `VEC_SOFT
      && !global_irq_enable_o)) else $error("soft trap not vectored");
   hard_vector_a: assert property ((st_r.fsm == irq_pkg::ST_HARD)
      |=> (redirect_o && redirect_pc_o == `VEC_HARD && !global_irq_enable_o))
      else $error("hard irq not vectored");
   hard_gate_a: assert property ((st_r.fsm == irq_pkg::ST_HARD) |-> $past(st_r.global_irq_enable))
      else $error("hard irq taken with global enable low");
   enable_instr_a: assert property ((enable_irq_instruction_i && st_r.fsm == irq_pkg::ST_RUN)
      |=> global_irq_enable_o) else $error("enable instruction ignored");
   disable_instr_a: assert property ((disable_irq_instruction_i && !enable_irq_instruction_i
      && st_r.fsm == irq_pkg::ST_RUN) |=> !global_irq_enable_o)
      else $error("disable instruction ignored");
   flag_sticky_a: assert property ((st_r.flags[`SRC_ADC] && !flag_write_i)
      |=> st_r.flags[`SRC_ADC]) else $error("flag dropped without write");
   event_wins_a: assert property ((events[`SRC_T0] && flag_write_i)
      |=> st_r.flags[`SRC_T0]) else $error("event lost to clear");
   view_gate_a: assert property ((!irq_enable_register_i[`SRC_WDT] && !flag_write_i)
      ##1 !$changed(irq_enable_register_i) |-> !irq_flag_register_o[`SRC_WDT])
      else $error("masked flag visible");
   return_pc_a: assert property ((return_from_isr_instruction_i && instr_done_i)
      |=> (redirect_o && redirect_pc_o == $past(st_r.ret) && global_irq_enable_o))
      else $error("return not resumed");
   cov_soft_c: cover property (redirect_o && redirect_pc_o == `VEC_SOFT);
   cov_hard_c: cover property (redirect_o && redirect_pc_o == `VEC_HARD);
   cov_nest_c: cover property (st_r.fsm == irq_pkg::ST_HARD ##[1:20] enable_irq_instruction_i);
   cov_clear_c: cover property (flag_write_i && |events);
endmodule // mcu_interrupt_unit

// file: logic/pin_change_detect.sv
`include "irq_cfg.svh"
// ***************************************************
// Port pin change and external edge detector
// ***************************************************
module pin_change_detect (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [7:0] porta_i,
   input wire logic [5:0] portb_i,
   input wire logic [7:0] porta_input_mode_i,
   input wire logic [5:0] portb_input_mode_i,
   input wire logic [7:0] porta_change_wake_enable_i,
   input wire logic [5:0] portb_change_wake_enable_i,
   input wire logic ext0_pin_select_i,
   input wire logic ext1_pin_select_i,
   input wire logic ext_edge_polarity_i,
   output logic pin_change_o,
   output logic ext0_edge_o,
   output logic ext1_edge_o
);
   typedef struct packed {
      logic [13:0] meta;
      logic [13:0] sync;
      logic [13:0] prev;
   } pcd_s;
   pcd_s st_r;
   pcd_s st_nxt;
   logic [13:0] wake_mask;
   logic [13:0] diff;
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = {portb_i, porta_i};
      st_nxt.sync = st_r.meta;
      st_nxt.prev = st_r.sync;
      wake_mask = {portb_change_wake_enable_i & portb_input_mode_i,
                   porta_change_wake_enable_i & porta_input_mode_i};
      // Pins claimed as edge inputs drop out of level-change sensing
      wake_mask[`PA_W + `PB_EXT0] = wake_mask[`PA_W + `PB_EXT0] & ~ext0_pin_select_i;
      wake_mask[`PA_W + `PB_EXT1] = wake_mask[`PA_W + `PB_EXT1] & ~ext1_pin_select_i;
      diff = st_r.sync ^ st_r.prev;
   end
   assign pin_change_o = |(diff & wake_mask);
   // Polarity high selects rising edge
   assign ext0_edge_o = ext0_pin_select_i & diff[`PA_W + `PB_EXT0]
      & (st_r.sync[`PA_W + `PB_EXT0] == ext_edge_polarity_i);
   assign ext1_edge_o = ext1_pin_select_i & diff[`PA_W + `PB_EXT1]
      & (st_r.sync[`PA_W + `PB_EXT1] == ext_edge_polarity_i);
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // pin_change_detect

// file: shared/irq_cfg.svh
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH
// ***************************************************
// Source numbering
// ***************************************************
`define SRC_COUNT 11
`define SRC_T0 0
`define SRC_T1 1
`define SRC_T2 2
`define SRC_T3 3
`define SRC_WDT 6
`define SRC_PIN 4
`define SRC_EXT0 5
`define SRC_EXT1 7
`define SRC_LVD 8
`define SRC_CMP 9
`define SRC_ADC 10
// ***************************************************
// Vectors and counter limits
// ***************************************************
`define PC_W 12
`define VEC_SOFT 12'h001
`define VEC_HARD 12'h008
`define T0_MAX 8'hFF
`define T0_MIN 8'h00
`define T13_MAX 10'h3FF
`define T13_MIN 10'h000
`define PA_W 8
`define PB_W 6
`define PB_EXT0 0
`define PB_EXT1 1
`define FLAGS_RST 11'h000
`endif

// file: shared/irq_pkg.sv
package irq_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_SOFT, ST_HARD} vec_state_e;
   typedef logic [10:0] src_vec_t;
endpackage

// file: sim/cpu_model.sv
// ***************************************************
// Instruction sequencer model
// ***************************************************
module cpu_model (
   input wire logic clock_i,
   input wire logic redirect_i,
   input wire logic [11:0] redirect_pc_i,
   output logic instr_done_o,
   output logic [11:0] next_pc_o,
   output logic [3:0] op_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Op bits: 0 trap, 1 enable, 2 disable, 3 return
   logic [11:0] pc = 12'h100;
   logic last_enable = 1'b0;
   int gap = 0;
   initial begin
      instr_done_o = 1'b0;
      next_pc_o = 12'h000;
      op_o = 4'h0;
   end
   always @(posedge clock_i) begin
      if (redirect_i) begin
         pc <= redirect_pc_i;
      end
   end
   task automatic step(input logic [3:0] op);
      repeat (gap) @(negedge clock_i);
      @(negedge clock_i);
      instr_done_o = 1'b1;
      next_pc_o = pc + 12'h001;
      op_o = op;
      pc = pc + 12'h001;
      @(negedge clock_i);
      instr_done_o = 1'b0;
      // Stale address is scrambled so nothing can lean on it
      next_pc_o = ~next_pc_o;
      op_o = 4'h0;
      last_enable = op[1];
   endtask
   task automatic run(input logic [3:0] op);
      // A spacer keeps enable from sitting right before return
      if (last_enable && op[3]) begin
         step(4'h0);
      end
      step(op);
   endtask
endmodule // cpu_model

// file: sim/mcu_interrupt_unit_test.sv
module mcu_interrupt_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic done;
   logic [11:0] npc;
   logic [3:0] op;
   logic [7:0] t0 = 8'h10;
   logic [9:0] t1 = 10'h005, t2 = 10'h005, t3 = 10'h005;
   logic wdt = 1'b0, wmode = 1'b0, lvd = 1'b1, cmp = 1'b0, oread = 1'b0, adc = 1'b0;
   logic [7:0] pa = 8'h00;
   logic [5:0] pb = 6'h00;
   logic [7:0] pim = 8'hFF, pwa = 8'hFF;
   logic [5:0] pbm = 6'h3F, pwb = 6'h3F;
   logic e0 = 1'b0, e1 = 1'b0, pol = 1'b1, wr = 1'b0;
   logic [10:0] en = 11'h000, wdata = 11'h7FF;
   logic [10:0] flags;
   logic global_irq_enable, redir;
   logic [11:0] rpc, retpc;
   int n_fail = 0;
   int num_checks = 0;

   always #10 clock_i = ~clock_i;

   cpu_model cpu (.clock_i, .redirect_i(redir), .redirect_pc_i(rpc), .instr_done_o(done),
      .next_pc_o(npc), .op_o(op));

   mcu_interrupt_unit dut (
      .clock_i, .rst_i, .instr_done_i(done), .next_pc_i(npc),
      .soft_trap_instruction_i(op[0]), .enable_irq_instruction_i(op[1]),
      .disable_irq_instruction_i(op[2]), .return_from_isr_instruction_i(op[3]),
      .timer0_count_i(t0), .timer1_count_i(t1), .timer2_count_i(t2), .timer3_count_i(t3),
      .watchdog_timeout_i(wdt), .watchdog_irq_mode_i(wmode), .porta_i(pa), .portb_i(pb),
      .porta_input_mode_i(pim), .portb_input_mode_i(pbm),
      .porta_change_wake_enable_i(pwa), .portb_change_wake_enable_i(pwb),
      .ext0_pin_select_i(e0), .ext1_pin_select_i(e1), .ext_edge_polarity_i(pol),
      .low_supply_ok_i(lvd), .comparator_out_i(cmp), .osc_ctrl_read_i(oread),
      .adc_done_i(adc), .irq_enable_register_i(en), .flag_write_i(wr),
      .flag_write_data_i(wdata), .irq_flag_register_o(flags), .global_irq_enable_o(global_irq_enable),
      .redirect_o(redir), .redirect_pc_o(rpc), .return_pc_o(retpc));

   // ***************************************************
   // Shared tasks
   // ***************************************************
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic clr();
      @(negedge clock_i);
      wr = 1'b1;
      wdata = 11'h000;
      @(negedge clock_i);
      wr = 1'b0;
      wdata = 11'h7FF;
      cyc(2);
      chk(12'(flags), 12'h000);
   endtask
   // Async sources need a few sync cycles before the flag shows
   task automatic ev(input logic [10:0] exp);
      cyc(6);
      chk(12'(flags), 12'(exp));
      clr();
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #100us;
      n_fail++;
      final_report();
   end

   // ***************************************************
   // Test sequence
   // ***************************************************
   initial begin
      cyc(5);
      rst_i = 1'b0;
      cyc(1);
      chk(12'(flags), 12'h000);
      chk(12'(global_irq_enable), 12'h000);
      cpu.run(4'b0001);
      cyc(1);
      chk(12'(redir), 12'h001);
      chk(rpc, 12'h001);
      chk(12'(global_irq_enable), 12'h000);
      chk(retpc, 12'h101);
      cpu.run(4'b1000);
      chk(12'(redir), 12'h001);
      chk(rpc, 12'h101);
      cyc(1);
      chk(12'(global_irq_enable), 12'h001);
      t0 = 8'hFF;
      cyc(1);
      t0 = 8'h00;
      cyc(3);
      chk(12'(flags), 12'h000);
      cpu.run(4'b0000);
      cyc(2);
      chk(12'(redir), 12'h000);
      en = 11'h001;
      cyc(2);
      chk(12'(flags), 12'h001);
      cpu.run(4'b0000);
      cyc(1);
      chk(12'(redir), 12'h001);
      chk(rpc, 12'h008);
      chk(12'(global_irq_enable), 12'h000);
      cpu.run(4'b0010);
      cyc(2);
      chk(12'(global_irq_enable), 12'h001);
      clr();
      cpu.gap = 2;
      cpu.run(4'b1000);
      cyc(1);
      chk(rpc, 12'h103);
      cpu.run(4'b0100);
      cyc(2);
      chk(12'(global_irq_enable), 12'h000);
      en = 11'h7FF;
      t0 = 8'hFF;
      cyc(1);
      t0 = 8'h00;
      cpu.run(4'b0000);
      cyc(2);
      chk(12'(redir), 12'h000);
      ev(11'h001);
      t1 = 10'h000;
      t2 = 10'h000;
      t3 = 10'h000;
      cyc(1);
      t1 = 10'h3FF;
      ev(11'h002);
      t2 = 10'h3FF;
      ev(11'h004);
      t3 = 10'h3FF;
      ev(11'h008);
      wdt = 1'b1;
      cyc(3);
      wdt = 1'b0;
      ev(11'h000);
      wmode = 1'b1;
      wdt = 1'b1;
      cyc(3);
      wdt = 1'b0;
      ev(11'h040);
      pa = 8'h08;
      ev(11'h010);
      pwa = 8'hF7;
      pa = 8'h00;
      ev(11'h000);
      pwa = 8'hFF;
      pim = 8'hF7;
      pa = 8'h08;
      ev(11'h000);
      pim = 8'hFF;
      pwb = 6'h3B;
      pb = 6'h04;
      ev(11'h000);
      pwb = 6'h3F;
      pbm = 6'h3B;
      pb = 6'h00;
      ev(11'h000);
      pbm = 6'h3F;
      e0 = 1'b1;
      cyc(2);
      pb = 6'h01;
      ev(11'h020);
      e1 = 1'b1;
      pol = 1'b0;
      cyc(2);
      pb = 6'h03;
      ev(11'h000);
      pb = 6'h01;
      ev(11'h080);
      lvd = 1'b0;
      ev(11'h100);
      lvd = 1'b1;
      ev(11'h000);
      cmp = 1'b1;
      ev(11'h000);
      oread = 1'b1;
      cyc(1);
      oread = 1'b0;
      cmp = 1'b0;
      ev(11'h200);
      adc = 1'b1;
      cyc(3);
      adc = 1'b0;
      ev(11'h400);
      // Clear lands on the same edge the wrap is seen
      t0 = 8'hFF;
      cyc(1);
      t0 = 8'h00;
      wr = 1'b1;
      wdata = 11'h000;
      cyc(1);
      wr = 1'b0;
      wdata = 11'h7FF;
      cyc(4);
      chk(12'(flags), 12'h001);
      final_report();
   end
endmodule // mcu_interrupt_unit_test
